// ===== src/pahbi_top.v
`timescale 1ns/1ps
`include "pahbi_defines.vh"
module pahbi_top #(
  parameter [31:0] BAR_BASE = 32'hE000_0000,
  parameter [31:0] BAR_MASK = 32'hFF00_0000
) (
  // clock, reset and bus mode
  input  wire        ref_clk_in,
  input  wire        srst_in,
  input  wire        agp_mode_in,
  // multiplexed address/data
  input  wire [31:0] ad_in,
  output reg  [31:0] ad_out,
  output reg         ad_oe_n_out,
  input  wire [3:0]  cbe_n_in,
  output reg  [3:0]  cbe_n_out,
  output reg         cbe_oe_n_out,
  input  wire        par_in,
  output reg         par_out,
  output reg         par_oe_n_out,
  // framing and handshake
  input  wire        frame_n_in,
  output reg         frame_n_out,
  output reg         frame_oe_n_out,
  input  wire        irdy_n_in,
  output reg         irdy_n_out,
  output reg         irdy_oe_n_out,
  input  wire        trdy_n_in,
  output reg         trdy_n_out,
  output reg         trdy_oe_n_out,
  input  wire        stop_n_in,
  output reg         stop_n_out,
  output reg         stop_oe_n_out,
  input  wire        devsel_n_in,
  output reg         devsel_n_out,
  output reg         devsel_oe_n_out,
  output reg         pipe_n_out,
  output reg         pipe_oe_n_out,
  // configuration select and arbitration
  input  wire        idsel_in,
  input  wire        gnt_n_in,
  input  wire [2:0]  agpst_in,
  output reg         req_n_out,
  // master user side
  input  wire        mst_req_in,
  input  wire [3:0]  mst_cmd_in,
  input  wire [31:0] mst_addr_in,
  input  wire [3:0]  mst_len_in,
  input  wire [31:0] mst_wdata_in,
  input  wire [3:0]  mst_be_in,
  output reg         mst_dacc_out,
  output reg  [31:0] mst_rdata_out,
  output reg         mst_done_out,
  output reg         mst_abort_out,
  output reg         mst_stopped_out,
  // agp request queue user side
  input  wire        agpq_valid_in,
  input  wire [3:0]  agpq_cmd_in,
  input  wire [31:0] agpq_addr_in,
  output wire        agpq_ready_out,
  // target user side
  output reg  [31:0] tgt_addr_out,
  output reg  [3:0]  tgt_cmd_out,
  output reg         tgt_sel_out,
  input  wire [31:0] tgt_rdata_in,
  output reg         tgt_wr_out,
  output reg  [31:0] tgt_wdata_out,
  output reg  [3:0]  tgt_be_out,
  output reg         tgt_rd_out
);

  // one-hot master states
  localparam [3:0] M_IDLE = 4'h1;
  localparam [3:0] M_ADDR = 4'h2;
  localparam [3:0] M_DATA = 4'h4;
  localparam [3:0] M_TURN = 4'h8;
  // one-hot target states
  localparam [3:0] T_IDLE = 4'h1;
  localparam [3:0] T_WAIT = 4'h2;
  localparam [3:0] T_DATA = 4'h4;
  localparam [3:0] T_TURN = 4'h8;

  reg [3:0] m_st_r;
  reg [3:0] t_st_r;
  reg [3:0] m_cnt_r;
  reg [2:0] m_wait_r;
  reg       m_wr_r;
  reg       m_dsel_r;
  reg       frame_d_r;
  reg       t_wr_r;
  reg       drv_par_r;

  // bus is idle when neither framing nor initiator ready is seen
  wire bus_idle = frame_n_in & irdy_n_in;
  wire granted  = ~gnt_n_in;
  wire st_start = granted & (agpst_in == `PAHBI_ST_START);
  // address phase seen from another master
  wire addr_seen = ~frame_n_in & frame_d_r & (m_st_r == M_IDLE);
  // completion and termination as seen on the lines
  wire done_ph = ~irdy_n_in & ~trdy_n_in;
  wire stop_ph = ~irdy_n_in & ~stop_n_in;
  wire cmd_cfg = (cbe_n_in == `PAHBI_CMD_CFG_RD) | (cbe_n_in == `PAHBI_CMD_CFG_WR);
  wire cmd_mem = (cbe_n_in == `PAHBI_CMD_MEM_RD) | (cbe_n_in == `PAHBI_CMD_MEM_WR);
  wire sel_cfg = agp_mode_in | idsel_in;
  wire hit_cfg = cmd_cfg & sel_cfg & (ad_in[1:0] == `PAHBI_CFG_TYPE0);
  wire hit_mem = cmd_mem & ((ad_in & BAR_MASK) == BAR_BASE);
  wire mst_go  = (m_st_r == M_IDLE) & mst_req_in & granted & bus_idle & (t_st_r == T_IDLE);

  assign agpq_ready_out = agp_mode_in & st_start & (m_st_r == M_IDLE) &
                          ~mst_req_in & (t_st_r == T_IDLE);

  // frame history sampled on the rising edge
  always @(posedge ref_clk_in) begin
    if (srst_in) begin
      frame_d_r <= `PAHBI_DEASSERT;
    end else begin
      frame_d_r <= frame_n_in;
    end
  end

  always @(posedge ref_clk_in) begin
    if (srst_in) begin
      req_n_out <= `PAHBI_DEASSERT;
    end else begin
      req_n_out <= ~((mst_req_in | agpq_valid_in) & (m_st_r == M_IDLE));
    end
  end

  // master sequencer with its pin drivers
  always @(posedge ref_clk_in) begin
    // reset releases lines and idles sequencer
    if (srst_in) begin
      m_st_r          <= M_IDLE;
      m_cnt_r         <= `PAHBI_ZERO4;
      m_wait_r        <= 3'h0;
      m_wr_r          <= 1'b0;
      m_dsel_r        <= 1'b0;
      frame_n_out     <= `PAHBI_DEASSERT;
      frame_oe_n_out  <= `PAHBI_REL;
      irdy_n_out      <= `PAHBI_DEASSERT;
      irdy_oe_n_out   <= `PAHBI_REL;
      pipe_n_out      <= `PAHBI_DEASSERT;
      pipe_oe_n_out   <= `PAHBI_REL;
      mst_dacc_out    <= 1'b0;
      mst_rdata_out   <= `PAHBI_ZERO32;
      mst_done_out    <= 1'b0;
      mst_abort_out   <= 1'b0;
      mst_stopped_out <= 1'b0;
    end else begin
      mst_dacc_out    <= 1'b0;
      mst_done_out    <= 1'b0;
      mst_abort_out   <= 1'b0;
      mst_stopped_out <= 1'b0;
      pipe_n_out      <= ~agpq_ready_out | ~agpq_valid_in;
      pipe_oe_n_out   <= ~(agp_mode_in & granted & (m_st_r == M_IDLE));
      case (m_st_r)
        M_IDLE: begin
          if (mst_go) begin
            m_st_r         <= M_ADDR;
            m_wr_r         <= mst_cmd_in[0];
            m_cnt_r        <= (mst_len_in == `PAHBI_ZERO4) ? 4'h1 : mst_len_in;
            m_wait_r       <= 3'h0;
            m_dsel_r       <= 1'b0;
            frame_n_out    <= 1'b0;
            frame_oe_n_out <= 1'b0;
            irdy_n_out     <= `PAHBI_DEASSERT;
            irdy_oe_n_out  <= 1'b0;
          end
        end
        M_ADDR: begin
          m_st_r <= M_DATA;
          // single phase releases frame at once
          frame_n_out <= (m_cnt_r == 4'h1);
          irdy_n_out  <= 1'b0;
        end
        M_DATA: begin
          if (~devsel_n_in) begin
            m_dsel_r <= 1'b1;
          end
          m_wait_r <= m_wait_r + 3'h1;
          // no device select in time: master abort
          if (~m_dsel_r & devsel_n_in & (m_wait_r == `PAHBI_ABORT_CYC)) begin
            m_st_r        <= M_TURN;
            frame_n_out   <= `PAHBI_DEASSERT;
            irdy_n_out    <= `PAHBI_DEASSERT;
            mst_abort_out <= 1'b1;
          end else if (done_ph | stop_ph) begin
            mst_dacc_out  <= done_ph;
            mst_rdata_out <= m_wr_r ? mst_rdata_out : ad_in;
            m_cnt_r       <= m_cnt_r - 4'h1;
            if ((m_cnt_r == 4'h1) | ~stop_n_in) begin
              if (frame_n_in) begin
                m_st_r          <= M_TURN;
                irdy_n_out      <= `PAHBI_DEASSERT;
                mst_done_out    <= 1'b1;
                mst_stopped_out <= ~stop_n_in;
              end
              frame_n_out <= `PAHBI_DEASSERT;
            end else begin
              frame_n_out <= (m_cnt_r == 4'h2);
            end
          end else if (~stop_n_in) begin
            frame_n_out <= `PAHBI_DEASSERT;
          end
        end
        M_TURN: begin
          // release lines after a turnaround cycle
          m_st_r         <= M_IDLE;
          frame_oe_n_out <= `PAHBI_REL;
          irdy_oe_n_out  <= `PAHBI_REL;
        end
        default: begin
          m_st_r <= M_IDLE;
        end
      endcase
    end
  end

  // target sequencer: claim, one data phase, disconnect
  always @(posedge ref_clk_in) begin
    if (srst_in) begin
      t_st_r          <= T_IDLE;
      t_wr_r          <= 1'b0;
      devsel_n_out    <= `PAHBI_DEASSERT;
      devsel_oe_n_out <= `PAHBI_REL;
      trdy_n_out      <= `PAHBI_DEASSERT;
      trdy_oe_n_out   <= `PAHBI_REL;
      stop_n_out      <= `PAHBI_DEASSERT;
      stop_oe_n_out   <= `PAHBI_REL;
      tgt_addr_out    <= `PAHBI_ZERO32;
      tgt_cmd_out     <= `PAHBI_ZERO4;
      tgt_sel_out     <= 1'b0;
      tgt_wr_out      <= 1'b0;
      tgt_rd_out      <= 1'b0;
      tgt_wdata_out   <= `PAHBI_ZERO32;
      tgt_be_out      <= `PAHBI_ZERO4;
    end else begin
      tgt_wr_out  <= 1'b0;
      tgt_rd_out  <= 1'b0;
      tgt_sel_out <= 1'b0;
      case (t_st_r)
        T_IDLE: begin
          if (addr_seen & (hit_cfg | hit_mem)) begin
            t_st_r          <= T_WAIT;
            t_wr_r          <= cbe_n_in[0];
            tgt_addr_out    <= ad_in;
            tgt_cmd_out     <= cbe_n_in;
            tgt_sel_out     <= 1'b1;
            devsel_n_out    <= 1'b0;
            devsel_oe_n_out <= 1'b0;
            trdy_oe_n_out   <= 1'b0;
            stop_oe_n_out   <= 1'b0;
          end
        end
        T_WAIT: begin
          // ready once read data is on the lines
          t_st_r     <= T_DATA;
          trdy_n_out <= 1'b0;
          stop_n_out <= frame_n_in ? `PAHBI_DEASSERT : 1'b0;
        end
        T_DATA: begin
          if (~frame_n_in) begin
            stop_n_out <= 1'b0;
          end
          if (~irdy_n_in) begin
            tgt_wr_out <= t_wr_r;
            tgt_rd_out <= ~t_wr_r;
            // byte enables taken in the data phase
            tgt_be_out <= ~cbe_n_in;
            if (t_wr_r) begin
              tgt_wdata_out <= ad_in;
            end
            trdy_n_out <= `PAHBI_DEASSERT;
            if (frame_n_in) begin
              t_st_r       <= T_TURN;
              devsel_n_out <= `PAHBI_DEASSERT;
              stop_n_out   <= `PAHBI_DEASSERT;
            end
          end else if (trdy_n_out & frame_n_in) begin
            t_st_r       <= T_TURN;
            devsel_n_out <= `PAHBI_DEASSERT;
            stop_n_out   <= `PAHBI_DEASSERT;
          end
        end
        T_TURN: begin
          t_st_r          <= T_IDLE;
          devsel_oe_n_out <= `PAHBI_REL;
          trdy_oe_n_out   <= `PAHBI_REL;
          stop_oe_n_out   <= `PAHBI_REL;
        end
        default: begin
          t_st_r <= T_IDLE;
        end
      endcase
    end
  end

  // address/data and command drivers
  always @(posedge ref_clk_in) begin
    if (srst_in) begin
      ad_out       <= `PAHBI_ZERO32;
      ad_oe_n_out  <= `PAHBI_REL;
      cbe_n_out    <= `PAHBI_ONES4;
      cbe_oe_n_out <= `PAHBI_REL;
    end else if (mst_go) begin
      ad_out       <= mst_addr_in;
      ad_oe_n_out  <= 1'b0;
      cbe_n_out    <= mst_cmd_in;
      cbe_oe_n_out <= 1'b0;
    end else if (agpq_ready_out & agpq_valid_in) begin
      ad_out       <= agpq_addr_in;
      ad_oe_n_out  <= 1'b0;
      cbe_n_out    <= agpq_cmd_in;
      cbe_oe_n_out <= 1'b0;
    end else if ((m_st_r == M_ADDR) | ((m_st_r == M_DATA) & ~frame_n_out)) begin
      // byte enables through the data phases
      ad_out       <= mst_wdata_in;
      ad_oe_n_out  <= ~m_wr_r;
      cbe_n_out    <= ~mst_be_in;
      cbe_oe_n_out <= 1'b0;
    end else if ((m_st_r == M_DATA) & ~(done_ph | stop_ph)) begin
      ad_out       <= mst_wdata_in;
      ad_oe_n_out  <= ~m_wr_r;
      cbe_n_out    <= ~mst_be_in;
      cbe_oe_n_out <= 1'b0;
    end else if ((t_st_r == T_WAIT) | ((t_st_r == T_DATA) & irdy_n_in & ~t_wr_r)) begin
      // read data presented by the target
      ad_out       <= tgt_rdata_in;
      ad_oe_n_out  <= t_wr_r;
      cbe_n_out    <= `PAHBI_ONES4;
      cbe_oe_n_out <= `PAHBI_REL;
    end else begin
      // released when not owning the lines
      ad_oe_n_out  <= `PAHBI_REL;
      cbe_oe_n_out <= `PAHBI_REL;
    end
  end

  // parity one clock behind the lines
  always @(posedge ref_clk_in) begin
    if (srst_in) begin
      drv_par_r    <= 1'b0;
      par_out      <= 1'b0;
      par_oe_n_out <= `PAHBI_REL;
    end else begin
      drv_par_r    <= ~ad_oe_n_out | ~cbe_oe_n_out;
      par_out      <= ^{ad_out, cbe_n_in}; // enables as seen on the lines
      par_oe_n_out <= ~(~ad_oe_n_out | (drv_par_r & ~cbe_oe_n_out & m_wr_r &
                        (m_st_r != M_IDLE)) | ((t_st_r == T_DATA) & ~t_wr_r));
    end
  end

endmodule

// ===== include/pahbi_defines.vh
`ifndef PAHBI_DEFINES_VH
`define PAHBI_DEFINES_VH
// bus commands on the command/byte-enable lines
`define PAHBI_CMD_MEM_RD   4'h6
`define PAHBI_CMD_MEM_WR   4'h7
`define PAHBI_CMD_CFG_RD   4'hA
`define PAHBI_CMD_CFG_WR   4'hB
// agp status code: permission to start a transaction
`define PAHBI_ST_START     3'h7
// cycles without a device select before master abort
`define PAHBI_ABORT_CYC    3'h5
// type-0 configuration address marker in ad[1:0]
`define PAHBI_CFG_TYPE0    2'h0
// reset values of released and deasserted lines
`define PAHBI_REL          1'h1
`define PAHBI_DEASSERT     1'h1
`define PAHBI_ZERO32       32'h0000_0000
`define PAHBI_ZERO4        4'h0
`define PAHBI_ONES4        4'hF
`endif

// ===== test/pahbi_chk.sv
`timescale 1ns/1ps
module pahbi_chk (
  // clock and reset
  input wire        ref_clk_in,
  input wire        srst_in,
  // watched bus lines
  input wire [31:0] ad_out,
  input wire [3:0]  cbe_n_out,
  input wire        ad_oe_n_out,
  input wire        cbe_oe_n_out,
  input wire        par_out,
  input wire        par_oe_n_out,
  input wire        frame_n_out,
  input wire        frame_oe_n_out,
  input wire        irdy_n_in,
  input wire        irdy_n_out,
  input wire        irdy_oe_n_out,
  input wire        trdy_n_in,
  input wire        trdy_n_out,
  input wire        trdy_oe_n_out,
  input wire        devsel_n_out,
  input wire        devsel_oe_n_out,
  input wire        gnt_n_in,
  input wire        req_n_out,
  // user side
  input wire        mst_req_in,
  input wire        mst_dacc_out,
  input wire        mst_done_out,
  input wire        mst_abort_out,
  input wire        tgt_sel_out
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (srst_in);
  // outputs released while reset is held
  a_reset_rel: assert property (disable iff (1'b0)
    srst_in |=> &{ad_oe_n_out, cbe_oe_n_out, par_oe_n_out, frame_oe_n_out,
    irdy_oe_n_out, trdy_oe_n_out, devsel_oe_n_out, req_n_out}) else $error("not released");
  a_par_even: assert property (
    !par_oe_n_out && $past(!ad_oe_n_out && !cbe_oe_n_out) |->
    par_out == ^{$past(ad_out), $past(cbe_n_out)}) else $error("bad parity");
  a_par_owner: assert property (
    ad_oe_n_out && $past(ad_oe_n_out) |-> par_oe_n_out) else $error("parity driven idle");
  a_frame_grant: assert property (
    $fell(frame_n_out) && !frame_oe_n_out |-> $past(!gnt_n_in)) else $error("no grant");
  a_addr_phase: assert property (
    $fell(frame_n_out) && !frame_oe_n_out |-> !ad_oe_n_out && !cbe_oe_n_out)
    else $error("address phase undriven");
  a_trans_ends: assert property (
    $fell(frame_n_out) && !frame_oe_n_out |-> ##[1:40] (mst_done_out || mst_abort_out))
    else $error("transaction never ends");
  a_req_raised: assert property (
    $rose(mst_req_in) && frame_oe_n_out |-> ##[1:2] !req_n_out) else $error("no request");
  a_dacc_cause: assert property (
    !irdy_oe_n_out && !irdy_n_out && !trdy_n_in |=> mst_dacc_out)
    else $error("phase not reported");
  a_dacc_only: assert property (
    mst_dacc_out |-> $past(!irdy_n_in && !trdy_n_in)) else $error("stray phase");
  a_tgt_claim: assert property (
    tgt_sel_out |-> !devsel_oe_n_out && !devsel_n_out ##1 !trdy_oe_n_out && !trdy_n_out)
    else $error("claim not driven");
  // main scenarios reached
  cover property (mst_done_out);
  cover property (mst_abort_out);
  cover property (tgt_sel_out);
endmodule
bind pahbi_top pahbi_chk u_chk (.ref_clk_in, .srst_in, .ad_out, .cbe_n_out, .ad_oe_n_out,
  .cbe_oe_n_out, .par_out, .par_oe_n_out, .frame_n_out, .frame_oe_n_out, .irdy_n_in,
  .irdy_n_out, .irdy_oe_n_out, .trdy_n_in, .trdy_n_out, .trdy_oe_n_out, .devsel_n_out,
  .devsel_oe_n_out, .gnt_n_in, .req_n_out, .mst_req_in, .mst_dacc_out, .mst_done_out,
  .mst_abort_out, .tgt_sel_out);

// ===== test/pahbi_core_model.sv
`timescale 1ns/1ps
// chipset target and arbiter facing the device as master
module pahbi_core_model #(
  parameter [31:0] RD_KEY = 32'h5A5A_A5A5
) (
  // clock and reset
  input  wire        clk_in,
  input  wire        rst_in,
  // resolved bus lines
  input  wire        req_n_in,
  input  wire        frame_n_in,
  input  wire        irdy_n_in,
  input  wire [31:0] ad_in,
  input  wire [3:0]  cbe_n_in,
  // knobs: wait states, no claim, disconnect
  input  wire [1:0]  wait_in,
  input  wire        mute_in,
  input  wire        stop_in,
  // lines the model drives
  output reg         gnt_n_out,
  output reg         trdy_n_out,
  output reg         devsel_n_out,
  output reg         stop_n_out,
  output reg         drv_out,
  output reg  [31:0] ad_out
);
  reg       fr_r;
  reg       act_r;
  reg       rd_r;
  reg [1:0] cnt_r;
  always @(posedge clk_in)
    gnt_n_out <= rst_in | req_n_in;
  always @(posedge clk_in) begin
    fr_r <= frame_n_in;
    if (rst_in || (act_r && !irdy_n_in && frame_n_in && (!trdy_n_out || !stop_n_out))) begin
      act_r <= 1'b0;
      trdy_n_out <= 1'b1;
      devsel_n_out <= 1'b1;
      stop_n_out <= 1'b1;
      drv_out <= 1'b0;
    end else if (!act_r && fr_r && !frame_n_in && !mute_in) begin
      act_r <= 1'b1;
      devsel_n_out <= 1'b0;
      cnt_r <= wait_in;
      rd_r <= !cbe_n_in[0];
      ad_out <= ad_in ^ RD_KEY;
    end else if (act_r) begin
      // read data after one turnaround cycle
      drv_out <= rd_r;
      if (cnt_r != 2'h0) begin
        cnt_r <= cnt_r - 2'h1;
      end else if (stop_n_out) begin
        trdy_n_out <= 1'b0;
        stop_n_out <= !stop_in;
      end else if (!irdy_n_in) begin
        // word taken under stop: hold stop until frame ends
        trdy_n_out <= 1'b1;
      end
      if (!irdy_n_in && !trdy_n_out)
        ad_out <= ad_out + 32'h1;
    end
  end
endmodule

// ===== test/tb_pci_agp_host_bus_interface.sv
`timescale 1ns/1ps
`include "pahbi_defines.vh"
module tb_pci_agp_host_bus_interface;
  localparam [31:0] RK = 32'h5A5A_A5A5;
  reg ref_clk_in = 0, srst_in = 1, agp_mode_in = 0, idsel_in = 0, mst_req_in = 0;
  reg agpq_valid_in = 0, tb_frame = 1, tb_irdy = 1, tb_drv = 0, mute = 0, stp = 0, par_q = 0;
  reg tk_q = 0;
  reg [1:0] wt = 0;
  reg [2:0] agpst_in = 0;
  reg [3:0] mst_cmd_in = 0, mst_len_in = 1, mst_be_in = 4'h5, agpq_cmd_in = 0, tb_cbe = 4'hF;
  reg [31:0] mst_addr_in = 0, mst_wdata_in = 0, agpq_addr_in = 0, tb_ad = 0, ad_last = 0;
  reg [31:0] tgt_rdata_in = 32'h1234_ABCD;
  reg [35:0] cq[$], pq[$];
  integer err_total = 0, checks = 0;
  wire [31:0] ad_out, mst_rdata_out, tgt_addr_out, tgt_wdata_out, m_ad;
  wire [3:0] cbe_n_out, tgt_cmd_out, tgt_be_out;
  wire ad_oe_n_out, cbe_oe_n_out, par_out, par_oe_n_out, frame_n_out, frame_oe_n_out;
  wire irdy_n_out, irdy_oe_n_out, trdy_n_out, trdy_oe_n_out, stop_n_out, stop_oe_n_out;
  wire devsel_n_out, devsel_oe_n_out, pipe_n_out, pipe_oe_n_out, req_n_out, agpq_ready_out;
  wire mst_dacc_out, mst_done_out, mst_abort_out, mst_stopped_out, tgt_sel_out;
  wire tgt_wr_out, tgt_rd_out, gnt_n_in, m_trdy, m_dev, m_stop, m_drv;
  // wire levels resolved from every party; idle ad toggles
  wire [31:0] ad_in = !ad_oe_n_out ? ad_out : m_drv ? m_ad : tb_drv ? tb_ad : ~ad_last;
  wire [3:0] cbe_n_in = !cbe_oe_n_out ? cbe_n_out : tb_cbe;
  wire frame_n_in = frame_oe_n_out ? tb_frame : frame_n_out;
  wire irdy_n_in = irdy_oe_n_out ? tb_irdy : irdy_n_out;
  wire trdy_n_in = trdy_oe_n_out ? m_trdy : trdy_n_out;
  wire stop_n_in = stop_oe_n_out ? m_stop : stop_n_out;
  wire devsel_n_in = devsel_oe_n_out ? m_dev : devsel_n_out;
  wire par_in = par_oe_n_out ? par_q : par_out;
  wire [7:0] oes = {ad_oe_n_out, cbe_oe_n_out, par_oe_n_out, frame_oe_n_out, irdy_oe_n_out,
    trdy_oe_n_out, stop_oe_n_out, devsel_oe_n_out};
  pahbi_top uut (.*);
  pahbi_core_model #(.RD_KEY(RK)) core (.clk_in(ref_clk_in), .rst_in(srst_in),
    .req_n_in(req_n_out), .frame_n_in(frame_n_in), .irdy_n_in(irdy_n_in), .ad_in(ad_in),
    .cbe_n_in(cbe_n_in), .wait_in(wt), .mute_in(mute), .stop_in(stp), .gnt_n_out(gnt_n_in),
    .trdy_n_out(m_trdy), .devsel_n_out(m_dev), .stop_n_out(m_stop), .drv_out(m_drv),
    .ad_out(m_ad));
  initial forever #2.5 ref_clk_in = ~ref_clk_in;
  // far-side parity, wire history, finished master phases and queued requests
  always @(posedge ref_clk_in) begin
    ad_last <= srst_in ? 32'h0 : ad_in;
    par_q <= ^{ad_in, cbe_n_in};
    tk_q <= agpq_valid_in & agpq_ready_out;
    if (!irdy_oe_n_out && !irdy_n_in && !trdy_n_in) cq.push_back({cbe_n_in, ad_in});
    if (!pipe_oe_n_out && !pipe_n_out) pq.push_back({cbe_n_in, ad_in});
  end
  task tick;
    begin
      @(posedge ref_clk_in);
      #1;
    end
  endtask
  task chk(input [95:0] nm, input [35:0] e, input [35:0] g);
    begin
      checks = checks + 1;
      if (g !== e) begin
        err_total = err_total + 1;
        $display("mismatch %0s exp %h got %h", nm, e, g);
      end
    end
  endtask
  task wrap_up;
    begin
      if (err_total == 0 && checks > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  // bus released once idle
  task idle_chk;
    begin
      repeat (3) tick;
      chk("released", 36'hFF, oes);
    end
  endtask
  // device as master against the chipset model
  task mst_run(input [3:0] c, input [31:0] a, input [3:0] l, input [3:0] ne, input [2:0] ef);
    integer n;
    integer k;
    reg [2:0] fin;
    begin
      mute = ef[2];
      mst_cmd_in = c;
      mst_addr_in = a;
      mst_len_in = l;
      mst_wdata_in = a;
      mst_req_in = 1'b1;
      cq.delete();
      k = 0;
      fin = 3'h0;
      for (n = 0; n < 60 && fin == 3'h0; n = n + 1) begin
        tick;
        if (mst_dacc_out === 1'b1 && !c[0]) chk("rdata", (a ^ RK) + k, mst_rdata_out);
        if (mst_dacc_out === 1'b1) k = k + 1;
        // next word must stand before the completing edge loads it
        mst_wdata_in = a + cq.size() + (irdy_n_in === 1'b0 && trdy_n_in === 1'b0);
        fin = {mst_abort_out, mst_stopped_out, mst_done_out};
      end
      mst_req_in = 1'b0;
      mute = 1'b0;
      if (fin == 3'h0) err_total = err_total + 1;
      if (fin == 3'h0) wrap_up;
      chk("ending", ef, fin);
      chk("phases", ne, cq.size());
      for (n = 0; n < cq.size(); n = n + 1)
        chk("wire", {~mst_be_in, c[0] ? a + n : (a ^ RK) + n}, cq[n]);
      idle_chk;
    end
  endtask
  // testbench as master, device as target
  task tgt_cyc(input [3:0] c, input [31:0] a, input s, input g, input ex);
    integer n;
    reg [2:0] saw;
    begin
      mute = 1'b1;
      idsel_in = s;
      agp_mode_in = g;
      tb_cbe = c;
      tb_ad = a;
      tb_drv = 1'b1;
      tb_frame = 1'b0;
      tick;
      saw = {2'h0, tgt_sel_out === 1'b1 && tgt_addr_out === a && tgt_cmd_out === c};
      tb_frame = 1'b1;
      tb_irdy = 1'b0;
      tb_cbe = 4'h0;
      tb_ad = ~a;
      tb_drv = c[0];
      for (n = 0; n < 8 && trdy_n_in !== 1'b0; n = n + 1)
        tick;
      if (!c[0] && trdy_n_in === 1'b0) chk("tdata", tgt_rdata_in, ad_in);
      for (n = 0; n < 2; n = n + 1) begin
        tick;
        if ((tgt_rd_out | tgt_wr_out) === 1'b1)
          saw[2:1] = {!c[0] || (tgt_wdata_out === ~a && tgt_be_out === 4'hF), 1'b1};
        tb_irdy = 1'b1;
        tb_drv = 1'b0;
      end
      chk("claim", {3{ex}}, saw);
      idle_chk;
      mute = 1'b0;
    end
  endtask
  // two back-to-back pipelined requests
  task pipe_q;
    integer n;
    integer k;
    begin
      agp_mode_in = 1'b1;
      agpst_in = `PAHBI_ST_START;
      pq.delete();
      agpq_cmd_in = 4'h2;
      agpq_addr_in = 32'h0000_1000;
      agpq_valid_in = 1'b1;
      k = 0;
      for (n = 0; n < 40 && k < 2; n = n + 1) begin
        tick;
        if (tk_q) k = k + 1;
        if (tk_q) agpq_addr_in = agpq_addr_in + 32'h40;
        if (tk_q) agpq_cmd_in = 4'h3;
        agpq_valid_in = k < 2;
      end
      repeat (4) tick;
      chk("queued", 36'h2, pq.size());
      chk("req0", 36'h2_0000_1000, pq[0]);
      chk("req1", 36'h3_0000_1040, pq[1]);
      agp_mode_in = 1'b0;
    end
  endtask
  // main sequence
  initial begin
    repeat (12) tick;
    chk("reset", 36'h1FF, {oes, req_n_out});
    srst_in = 1'b0;
    tick;
    wt = 2'h2;
    mst_run(`PAHBI_CMD_MEM_WR, 32'h0010_0000, 4'h2, 4'h2, 3'b001);
    wt = 2'h0;
    mst_run(`PAHBI_CMD_MEM_RD, 32'h0020_0000, 4'h3, 4'h3, 3'b001);
    mst_run(`PAHBI_CMD_MEM_RD, 32'h0030_0000, 4'h0, 4'h1, 3'b001);
    mst_run(`PAHBI_CMD_MEM_RD, 32'h0040_0000, 4'h1, 4'h0, 3'b100);
    stp = 1'b1;
    mst_run(`PAHBI_CMD_MEM_WR, 32'h0050_0000, 4'h4, 4'h1, 3'b011);
    stp = 1'b0;
    tgt_cyc(`PAHBI_CMD_MEM_RD, 32'hE000_0010, 1'b0, 1'b0, 1'b1);
    tgt_cyc(`PAHBI_CMD_MEM_WR, 32'hE000_0020, 1'b0, 1'b0, 1'b1);
    tgt_cyc(`PAHBI_CMD_CFG_RD, 32'h0000_0010, 1'b1, 1'b0, 1'b1);
    tgt_cyc(`PAHBI_CMD_CFG_WR, 32'h0000_0014, 1'b0, 1'b0, 1'b0);
    tgt_cyc(`PAHBI_CMD_CFG_RD, 32'h0000_0010, 1'b0, 1'b1, 1'b1);
    tgt_cyc(`PAHBI_CMD_MEM_RD, 32'h1000_0000, 1'b0, 1'b0, 1'b0);
    pipe_q;
    wrap_up;
  end
endmodule
